// ---- verilog/ctb_pkg.sv ----
// Functional notes
// - Periodic and timeout modes flag at TOP.
// - Single-shot mode flags at TOP.
// - Capture-on-event loads capture and flags on event.
// - Frequency mode captures, restarts count, flags.
// - Pulse-width: restart one edge, capture opposite.
// - Combined mode stops and flags on third edge.
// - PWM mode flags at high compare byte.
// - Flag clears on write-one or capture read.
// - Running bit is read-only counter status.
// - Halted processor without bypass freezes block.
// - Bypass bit keeps block running while halted.
// - One shared byte staging register.
// - Counter bytes at base and base plus one.
// - Bus write beats internal counter update.
// - Capture/compare bytes at base and next.
// - Capture stores present counter value.
// - Capture/compare is TOP in timed modes.
// - PWM mode uses compare bytes independently.
// - Three-bit mode field decodes eight modes.
// - Interrupt request equals enable and flag.

package ctb_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [3:0] OFF_CAPTURE_FLAGS = 4'h6;
  localparam logic [3:0] OFF_RUN_STATE     = 4'h7;
  localparam logic [3:0] OFF_DEBUG_CONTROL = 4'h8;
  localparam logic [3:0] OFF_BYTE_STAGING  = 4'h9;
  localparam logic [3:0] OFF_COUNTER_LO    = 4'ha;
  localparam logic [3:0] OFF_COUNTER_HI    = 4'hb;
  localparam logic [3:0] OFF_CCV_LO        = 4'hc;
  localparam logic [3:0] OFF_CCV_HI        = 4'hd;

  // ==========================================================================
  // Field positions and reset values
  localparam int          CAPTURE_FLAG_BIT = 0;
  localparam int          RUN_BIT          = 0;
  localparam int          HALT_BYPASS_BIT  = 0;
  localparam int          COUNT_W          = 16;
  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [15:0] RST_WORD         = 16'h0000;

  // ==========================================================================
  // Timer modes
  typedef enum logic [2:0] {
    MODE_PERIODIC      = 3'h0,
    MODE_TIMEOUT       = 3'h1,
    MODE_CAPTURE_EVENT = 3'h2,
    MODE_FREQ          = 3'h3,
    MODE_PULSE_W       = 3'h4,
    MODE_FREQ_PW       = 3'h5,
    MODE_SINGLE        = 3'h6,
    MODE_PWM8          = 3'h7
  } ctb_mode_t;

  // Phases of the combined frequency and pulse-width measurement.
  typedef enum logic [1:0] {
    FPW_IDLE        = 2'h0,
    FPW_WAIT_OPP    = 2'h1,
    FPW_WAIT_SECOND = 2'h2,
    FPW_DONE        = 2'h3
  } ctb_fpw_t;

endpackage : ctb_pkg

// ---- verilog/ctb_edge_detect.sv ----
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Event edge qualifier
module ctb_edge_detect
(
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  input  wire logic event_in,
  input  wire logic edge_select_in,
  input  wire logic gate_in,
  output logic      sel_edge_out,
  output logic      opp_edge_out
);

  typedef struct packed {
    logic prev;
  } ctb_edge_state_t;

  ctb_edge_state_t q;
  ctb_edge_state_t next_q;
  logic            rise;
  logic            fall;

  // The previous level keeps tracking while gated, so that releasing the
  // gate does not invent an edge from a stale sample.
  always_comb
  begin
    next_q      = q;
    next_q.prev = event_in;
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  // The selected edge is positive when the select input is low.
  assign rise         = event_in & ~q.prev;
  assign fall         = ~event_in & q.prev;
  assign sel_edge_out = gate_in & (edge_select_in ? fall : rise);
  assign opp_edge_out = gate_in & (edge_select_in ? rise : fall);

endmodule : ctb_edge_detect

`default_nettype wire

// ---- verilog/ctb_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Capture timer core with status registers
module ctb_timer
#(
  parameter int COUNT_WIDTH = ctb_pkg::COUNT_W
)
(
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic [3:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       enable_in,
  input  wire logic [2:0] timer_mode_select_in,
  input  wire logic       event_edge_in,
  input  wire logic       capture_event_enable_in,
  input  wire logic       capture_irq_enable_in,
  input  wire logic       event_in,
  input  wire logic       cpu_halted_in,
  output logic            capture_irq_out,
  output logic            counter_running_out
);

  // ==========================================================================
  // Elaboration check
  if (COUNT_WIDTH != 16)
  begin : g_width_check
    $error("ctb_timer supports only a 16-bit counter");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    logic [15:0]       cnt;
    logic [15:0]       ccv;
    logic [7:0]        staging;
    logic              capture_flag;
    logic              run;
    logic              halt_bypass;
    ctb_pkg::ctb_fpw_t fpw_phase;
    logic [7:0]        rdata;
  } ctb_state_t;

  ctb_state_t         q;
  ctb_state_t         next_q;
  ctb_pkg::ctb_mode_t mode;
  logic               active;
  logic               sel_edge;
  logic               opp_edge;
  logic               hit_top;
  logic               set_flag;
  logic               clr_flag;
  logic               capture_mode;
  logic               wr_cnt_hi;

  // Address match, used by both the read and the write paths.
  function automatic logic hit(input logic [3:0] off);
    hit = (reg_addr_in == off);
  endfunction : hit

  // The block runs while enabled, unless the processor is halted and bypass is off.
  assign active = enable_in & (~cpu_halted_in | q.halt_bypass);
  assign mode   = ctb_pkg::ctb_mode_t'(timer_mode_select_in);

  // Modes whose compare register holds a captured count.
  assign capture_mode = (mode == ctb_pkg::MODE_CAPTURE_EVENT) |
                        (mode == ctb_pkg::MODE_FREQ) |
                        (mode == ctb_pkg::MODE_PULSE_W) |
                        (mode == ctb_pkg::MODE_FREQ_PW);

  // Events are ignored while frozen, not queued for later.
  ctb_edge_detect ctb_edge_detect_i
  (
    .core_clk_in    (core_clk_in),
    .rst_in         (rst_in),
    .event_in       (event_in),
    .edge_select_in (event_edge_in),
    .gate_in        (active & capture_event_enable_in),
    .sel_edge_out   (sel_edge),
    .opp_edge_out   (opp_edge)
  );

  assign hit_top   = (q.cnt == q.ccv);
  assign wr_cnt_hi = reg_wr_in & hit(ctb_pkg::OFF_COUNTER_HI);

  // ==========================================================================
  // Next state: counting first, then bus accesses, so a bus write to the
  // counter overrides whatever the counting logic chose this cycle.
  always_comb
  begin
    next_q   = q;
    set_flag = 1'b0;
    clr_flag = 1'b0;
    if (!enable_in)
    begin
      next_q.run       = 1'b0;
      next_q.fpw_phase = ctb_pkg::FPW_IDLE;
    end
    else if (active)
    begin
      case (mode)
        ctb_pkg::MODE_PERIODIC:
        begin
          next_q.run = 1'b1;
          if (hit_top)
          begin
            next_q.cnt = '0;
            set_flag   = 1'b1;
          end
          else
          begin
            next_q.cnt = q.cnt + 16'h0001;
          end
        end
        ctb_pkg::MODE_TIMEOUT:
        begin
          // Start on the selected edge, stop on the opposite one.
          if (sel_edge)
          begin
            next_q.run = 1'b1;
            next_q.cnt = '0;
          end
          else if (opp_edge)
          begin
            next_q.run = 1'b0;
          end
          else if (q.run && hit_top)
          begin
            next_q.cnt = '0;
            set_flag   = 1'b1;
          end
          else if (q.run)
          begin
            next_q.cnt = q.cnt + 16'h0001;
          end
        end
        ctb_pkg::MODE_CAPTURE_EVENT:
        begin
          next_q.run = 1'b1;
          next_q.cnt = q.cnt + 16'h0001;
          if (sel_edge)
          begin
            next_q.ccv = q.cnt;
            set_flag   = 1'b1;
          end
        end
        ctb_pkg::MODE_FREQ:
        begin
          next_q.run = 1'b1;
          next_q.cnt = q.cnt + 16'h0001;
          if (sel_edge)
          begin
            next_q.ccv = q.cnt;
            next_q.cnt = '0;
            set_flag   = 1'b1;
          end
        end
        ctb_pkg::MODE_PULSE_W:
        begin
          next_q.run = 1'b1;
          next_q.cnt = q.cnt + 16'h0001;
          if (sel_edge)
          begin
            next_q.cnt = '0;
          end
          else if (opp_edge)
          begin
            next_q.ccv = q.cnt;
            set_flag   = 1'b1;
          end
        end
        ctb_pkg::MODE_FREQ_PW:
        begin
          if (q.run)
          begin
            next_q.cnt = q.cnt + 16'h0001;
          end
          case (q.fpw_phase)
            ctb_pkg::FPW_IDLE:
            begin
              if (sel_edge)
              begin
                next_q.cnt       = '0;
                next_q.run       = 1'b1;
                next_q.fpw_phase = ctb_pkg::FPW_WAIT_OPP;
              end
            end
            ctb_pkg::FPW_WAIT_OPP:
            begin
              if (opp_edge)
              begin
                next_q.ccv       = q.cnt;
                next_q.fpw_phase = ctb_pkg::FPW_WAIT_SECOND;
              end
            end
            ctb_pkg::FPW_WAIT_SECOND:
            begin
              if (sel_edge)
              begin
                next_q.cnt       = q.cnt;
                next_q.run       = 1'b0;
                set_flag         = 1'b1;
                next_q.fpw_phase = ctb_pkg::FPW_DONE;
              end
            end
            default:
            begin
              // Rearm once software has taken the result.
              if (!q.capture_flag)
              begin
                next_q.fpw_phase = ctb_pkg::FPW_IDLE;
              end
            end
          endcase
        end
        ctb_pkg::MODE_SINGLE:
        begin
          if (q.run && hit_top)
          begin
            next_q.run = 1'b0;
            set_flag   = 1'b1;
          end
          else if (q.run)
          begin
            next_q.cnt = q.cnt + 16'h0001;
          end
          else if (sel_edge)
          begin
            next_q.run = 1'b1;
            next_q.cnt = '0;
          end
        end
        default:
        begin
          // 8-bit PWM: low compare byte is the period, high byte the duty.
          next_q.run = 1'b1;
          if (q.cnt[7:0] == q.ccv[7:0])
          begin
            next_q.cnt = '0;
          end
          else
          begin
            next_q.cnt = {8'h00, q.cnt[7:0] + 8'h01};
          end
          if (q.cnt[7:0] == q.ccv[15:8])
          begin
            set_flag = 1'b1;
          end
        end
      endcase
    end

    // Register reads; data appears one cycle after the strobe.
    next_q.rdata = ctb_pkg::RST_BYTE;
    if (reg_rd_in)
    begin
      if (hit(ctb_pkg::OFF_CAPTURE_FLAGS))
      begin
        next_q.rdata[ctb_pkg::CAPTURE_FLAG_BIT] = q.capture_flag;
      end
      if (hit(ctb_pkg::OFF_RUN_STATE))
      begin
        next_q.rdata[ctb_pkg::RUN_BIT] = q.run;
      end
      if (hit(ctb_pkg::OFF_DEBUG_CONTROL))
      begin
        next_q.rdata[ctb_pkg::HALT_BYPASS_BIT] = q.halt_bypass;
      end
      if (hit(ctb_pkg::OFF_BYTE_STAGING))
      begin
        next_q.rdata = q.staging;
      end
      if (hit(ctb_pkg::OFF_COUNTER_LO))
      begin
        next_q.rdata   = q.cnt[7:0];
        next_q.staging = q.cnt[15:8];
      end
      if (hit(ctb_pkg::OFF_COUNTER_HI))
      begin
        next_q.rdata = q.staging;
      end
      if (hit(ctb_pkg::OFF_CCV_LO))
      begin
        next_q.rdata = q.ccv[7:0];
        if (mode != ctb_pkg::MODE_PWM8)
        begin
          next_q.staging = q.ccv[15:8];
        end
        clr_flag = capture_mode;
      end
      if (hit(ctb_pkg::OFF_CCV_HI))
      begin
        next_q.rdata = (mode == ctb_pkg::MODE_PWM8) ? q.ccv[15:8]
                                                    : q.staging;
      end
    end

    // Register writes; the run state has no write path at all.
    if (reg_wr_in)
    begin
      if (hit(ctb_pkg::OFF_CAPTURE_FLAGS) &&
          reg_wdata_in[ctb_pkg::CAPTURE_FLAG_BIT])
      begin
        clr_flag = 1'b1;
      end
      if (hit(ctb_pkg::OFF_DEBUG_CONTROL))
      begin
        next_q.halt_bypass = reg_wdata_in[ctb_pkg::HALT_BYPASS_BIT];
      end
      if (hit(ctb_pkg::OFF_BYTE_STAGING) || hit(ctb_pkg::OFF_COUNTER_LO))
      begin
        next_q.staging = reg_wdata_in;
      end
      if (hit(ctb_pkg::OFF_COUNTER_HI))
      begin
        next_q.cnt = {reg_wdata_in, q.staging};
      end
      if (hit(ctb_pkg::OFF_CCV_LO))
      begin
        if (mode == ctb_pkg::MODE_PWM8)
        begin
          next_q.ccv[7:0] = reg_wdata_in;
        end
        else
        begin
          next_q.staging = reg_wdata_in;
        end
      end
      if (hit(ctb_pkg::OFF_CCV_HI))
      begin
        if (mode == ctb_pkg::MODE_PWM8)
        begin
          next_q.ccv[15:8] = reg_wdata_in;
        end
        else
        begin
          next_q.ccv = {reg_wdata_in, q.staging};
        end
      end
    end

    // A new event in the clearing cycle must not be lost, so set wins.
    if (set_flag)
    begin
      next_q.capture_flag = 1'b1;
    end
    else if (clr_flag)
    begin
      next_q.capture_flag = 1'b0;
    end
  end

  // Every field resets to zero.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  // Outputs.
  assign reg_rdata_out       = q.rdata;
  assign capture_irq_out     = capture_irq_enable_in & q.capture_flag;
  assign counter_running_out = q.run;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_cnt_hi_write;
    wr_cnt_hi;
  endsequence

  sequence s_periodic_top;
    active && mode == ctb_pkg::MODE_PERIODIC && hit_top && !reg_wr_in;
  endsequence

  property p_periodic_top;
    s_periodic_top |=> q.capture_flag && q.cnt == 16'h0000;
  endproperty
  a_periodic_top: assert property (p_periodic_top)
    else $error("periodic TOP did not flag and wrap");

  property p_capture_load;
    (active && mode == ctb_pkg::MODE_CAPTURE_EVENT && sel_edge &&
     !reg_wr_in)
      |=> q.capture_flag && q.ccv == $past(q.cnt);
  endproperty
  a_capture_load: assert property (p_capture_load)
    else $error("capture event did not load and flag");

  property p_freq_restart;
    (active && mode == ctb_pkg::MODE_FREQ && sel_edge && !reg_wr_in)
      |=> q.cnt == 16'h0000 && q.capture_flag;
  endproperty
  a_freq_restart: assert property (p_freq_restart)
    else $error("frequency edge did not restart and flag");

  property p_flag_clear;
    (reg_wr_in && hit(ctb_pkg::OFF_CAPTURE_FLAGS) && reg_wdata_in[0]
     && !set_flag) |=> !q.capture_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("write one did not clear capture flag");

  property p_run_read;
    (reg_rd_in && hit(ctb_pkg::OFF_RUN_STATE))
      |=> reg_rdata_out == {7'h00, $past(q.run)};
  endproperty
  a_run_read: assert property (p_run_read)
    else $error("run state read mismatch");

  property p_halt_freeze;
    (enable_in && cpu_halted_in && !q.halt_bypass && !reg_wr_in &&
     !reg_rd_in)
      |=> $stable(q.cnt) && $stable(q.capture_flag);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze)
    else $error("counter moved while halted");

  property p_write_priority;
    s_cnt_hi_write |=> q.cnt == {$past(reg_wdata_in), $past(q.staging)};
  endproperty
  a_write_priority: assert property (p_write_priority)
    else $error("bus write to counter lost");

  property p_irq;
    capture_irq_out == (capture_irq_enable_in && q.capture_flag);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request mismatch");

  property p_lo_latch;
    (reg_rd_in && hit(ctb_pkg::OFF_COUNTER_LO))
      |=> q.staging == $past(q.cnt[15:8]);
  endproperty
  a_lo_latch: assert property (p_lo_latch)
    else $error("low counter read did not latch high byte");

endmodule : ctb_timer

`default_nettype wire

// ---- verif/ctb_timer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module ctb_timer_tb;

  // ==========================================================================
  // Bench signals
  localparam logic [3:0] A_FLG = ctb_pkg::OFF_CAPTURE_FLAGS;
  localparam logic [3:0] A_RUN = ctb_pkg::OFF_RUN_STATE;
  localparam logic [3:0] A_DBG = ctb_pkg::OFF_DEBUG_CONTROL;
  localparam logic [3:0] A_TMP = ctb_pkg::OFF_BYTE_STAGING;
  localparam logic [3:0] A_CNT = ctb_pkg::OFF_COUNTER_LO;
  localparam logic [3:0] A_CCV = ctb_pkg::OFF_CCV_LO;
  logic       core_clk   = 1'b0;
  logic       rst        = 1'b1;
  logic [3:0] addr       = 4'h0;
  logic       wr         = 1'b0;
  logic       rd         = 1'b0;
  logic [7:0] wdata      = 8'h00;
  logic       en         = 1'b0;
  logic [2:0] mode       = 3'h0;
  logic       edge_sel   = 1'b0;
  logic       cap_en     = 1'b0;
  logic       irq_en     = 1'b0;
  logic       evt        = 1'b0;
  logic       halted     = 1'b0;
  logic [7:0] rdata;
  logic       irq;
  logic       running;
  int         n_errors   = 0;
  int         n_compared = 0;
  int         cycles     = 0;
  integer     seed       = 43886;

  ctb_timer ctb_timer_i (
    .core_clk_in             (core_clk),
    .rst_in                  (rst),
    .reg_addr_in             (addr),
    .reg_wr_in               (wr),
    .reg_rd_in               (rd),
    .reg_wdata_in            (wdata),
    .reg_rdata_out           (rdata),
    .enable_in               (en),
    .timer_mode_select_in    (mode),
    .event_edge_in           (edge_sel),
    .capture_event_enable_in (cap_en),
    .capture_irq_enable_in   (irq_en),
    .event_in                (evt),
    .cpu_halted_in           (halted),
    .capture_irq_out         (irq),
    .counter_running_out     (running)
  );

  // Free-running 40 MHz clock.
  always #12.5 core_clk = ~core_clk;

  // A hung handshake must not stall the run, so cycles are capped.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic complete_run();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string what);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t %s: saw %h, expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // A captured count is taken one cycle before the edge that restarts it.
  function automatic logic [15:0] exp_capture(input int gap);
    return 16'(gap - 1);
  endfunction : exp_capture

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // Strobes rise after one edge and drop after the edge that takes them.
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
                        input string what);
    logic [7:0] d;
    rd_reg(a, d);
    chk({8'h00, d}, {8'h00, e}, what);
  endtask : rd_chk

  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr_reg(a, v[7:0]);
    wr_reg(a + 4'h1, v[15:8]);
  endtask : wr16

  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd_reg(a, lo);
    rd_reg(a + 4'h1, hi);
    v = {hi, lo};
  endtask : rd16

  task automatic cfg(input logic [2:0] m, input logic e, input logic c,
                     input logic ie, input logic h);
    @(posedge core_clk);
    mode   <= m;
    en     <= e;
    cap_en <= c;
    irq_en <= ie;
    halted <= h;
  endtask : cfg

  task automatic set_evt(input logic v);
    @(posedge core_clk);
    evt <= v ^ edge_sel;
  endtask : set_evt

  task automatic wait_irq(output int n);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (irq !== 1'b1 && n < 3000);
  endtask : wait_irq

  // Two flags apart, with a clear between them, span one full period.
  task automatic period_chk(input int top);
    int n;
    wait_irq(n);
    wr_reg(A_FLG, 8'h01);
    wait_irq(n);
    chk(16'(n + 2), 16'(top + 1), "flag period");
  endtask : period_chk

  // ==========================================================================
  // Main sequence
  initial
  begin : main
    logic [15:0] v;
    logic [15:0] w;
    logic        e;
    int          t;
    int          n;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++)
      rd_chk(4'(a), 8'h00, "reset or hole");
    // Paired access and the one shared staging byte.
    v = 16'($random(seed));
    wr16(A_CNT, v);
    rd16(A_CNT, w);
    chk(w, v, "counter pair");
    wr16(A_CCV, ~v);
    rd16(A_CCV, w);
    chk(w, ~v, "compare pair");
    rd_chk(A_TMP, w[15:8], "staging latch");
    wr_reg(A_TMP, 8'h5a);
    wr_reg(A_CNT + 4'h1, 8'hc3);
    rd16(A_CNT, w);
    chk(w, 16'hc35a, "staging commit");
    wr_reg(A_RUN, 8'hff);
    rd_chk(A_RUN, 8'h00, "run write");
    wr_reg(A_DBG, 8'h01);
    rd_chk(A_DBG, 8'h01, "debug bit");
    wr_reg(A_DBG, 8'h00);
    // Periodic and timeout modes wrap at the compare value.
    for (int m = 0; m < 2; m++)
    begin
      t = 16 + ($unsigned($random(seed)) % 48);
      cfg(3'h0, 1'b0, 1'b0, 1'b1, 1'b0);
      // A flag left from the last mode would end the first wait early.
      wr_reg(A_FLG, 8'h01);
      wr16(A_CCV, 16'(t));
      wr16(A_CNT, 16'h0000);
      cfg(3'(m), 1'b1, 1'b1, 1'b1, 1'b0);
      set_evt(1'b1);
      period_chk(t);
      set_evt(1'b0);
    end
    cfg(3'h1, 1'b1, 1'b1, 1'b0, 1'b0);
    #1;
    chk({15'h0, irq}, 16'h0, "masked request");
    rd_chk(A_FLG, 8'h01, "flag kept");
    wr_reg(A_FLG, 8'h01);
    rd_chk(A_FLG, 8'h00, "write one clears");
    // Single-shot waits for its edge, flags at the top, then stops.
    cfg(3'h6, 1'b1, 1'b1, 1'b1, 1'b0);
    rd_chk(A_RUN, 8'h00, "armed idle");
    set_evt(1'b1);
    wait_irq(n);
    chk(16'(n >= t + 1 && n <= t + 3), 16'h1, "shot length");
    rd_chk(A_RUN, 8'h00, "shot stopped");
    chk({15'h0, running}, 16'h0, "run output idle");
    set_evt(1'b0);
    // Frequency, pulse width and both combined, either polarity.
    for (int m = 3; m < 6; m++)
    begin
      t = 12 + ($unsigned($random(seed)) % 40);
      e = 1'($random(seed));
      cfg(3'(m), 1'b1, 1'b0, 1'b1, 1'b0);
      edge_sel <= e;
      evt      <= e;
      wr_reg(A_FLG, 8'h01);
      cfg(3'(m), 1'b1, 1'b1, 1'b1, 1'b0);
      set_evt(1'b1);
      if (m == 3)
      begin
        set_evt(1'b0);
        tick(t - 2);
        set_evt(1'b1);
      end
      else
      begin
        tick(t - 1);
        set_evt(1'b0);
        if (m == 5)
        begin
          tick(t);
          set_evt(1'b1);
        end
      end
      tick(2);
      rd_chk(A_FLG, 8'h01, "capture flag");
      rd_chk(A_RUN, 8'(m != 5), "run after capture");
      rd16(A_CCV, w);
      chk(w, exp_capture(t), "captured count");
      rd_chk(A_FLG, 8'h00, "capture read clears");
      cfg(3'(m), 1'b1, 1'b0, 1'b1, 1'b0);
      set_evt(1'b0);
    end
    @(posedge core_clk);
    edge_sel <= 1'b0;
    evt      <= 1'b0;
    // Halted without bypass freezes the count and drops events.
    cfg(3'h2, 1'b1, 1'b1, 1'b1, 1'b1);
    wr_reg(A_FLG, 8'h01);
    rd16(A_CNT, v);
    tick(8);
    rd16(A_CNT, w);
    chk(w, v, "frozen count");
    set_evt(1'b1);
    tick(2);
    set_evt(1'b0);
    rd_chk(A_FLG, 8'h00, "halted event");
    wr_reg(A_DBG, 8'h01);
    rd16(A_CNT, v);
    tick(8);
    rd16(A_CNT, w);
    chk(w - v, 16'd12, "bypass count");
    set_evt(1'b1);
    tick(2);
    rd_chk(A_FLG, 8'h01, "event capture");
    wr_reg(A_FLG, 8'h01);
    set_evt(1'b0);
    tick(2);
    rd_chk(A_FLG, 8'h00, "opposite edge");
    // A bus write wins over the running count.
    cfg(3'h0, 1'b1, 1'b0, 1'b1, 1'b0);
    wr_reg(A_DBG, 8'h00);
    wr16(A_CCV, 16'hffff);
    v = 16'($random(seed)) & 16'h7fff;
    wr16(A_CNT, v);
    rd16(A_CNT, w);
    chk(w, v + 16'h1, "write priority");
    // Eight-bit PWM keeps the compare bytes apart.
    t = 16 + ($unsigned($random(seed)) % 32);
    cfg(3'h7, 1'b0, 1'b0, 1'b1, 1'b0);
    wr_reg(A_CCV, 8'(t));
    wr_reg(A_TMP, 8'ha5);
    wr_reg(A_CCV + 4'h1, 8'(t / 2));
    rd_chk(A_CCV, 8'(t), "pwm low byte");
    rd_chk(A_CCV + 4'h1, 8'(t / 2), "pwm high byte");
    wr16(A_CNT, 16'h0000);
    wr_reg(A_FLG, 8'h01);
    cfg(3'h7, 1'b1, 1'b0, 1'b1, 1'b0);
    period_chk(t);
    rd_chk(A_RUN, 8'h01, "pwm running");
    chk({15'h0, running}, 16'h1, "run output busy");
    complete_run();
  end

endmodule : ctb_timer_tb

`default_nettype wire
